// ===== rtl/ngr_regs.sv
// received next page and gigabit control registers behind avalon-mm
`default_nettype none

module ngr_regs
  import ngr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_page_valid,
  input wire logic [REG_W-1:0] i_page_word,
  input wire logic i_strap_repeater,
  input wire logic i_an_enable,
  output logic [2:0] o_test_mode,
  output logic o_ms_manual_en,
  output logic o_ms_force_master,
  output logic o_adv_repeater,
  output logic o_page_received,
  output logic o_alt_bit_error
);

  // ----------------------------------------------------------------
  // bus handshake and strap capture
  // ----------------------------------------------------------------
  logic bus_load;
  logic bus_take;
  logic strap_value;
  logic strap_load;

  ngr_bus_slave u_bus (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_read(i_avs_read),
    .i_write(i_avs_write),
    .o_waitrequest(o_avs_waitrequest),
    .o_load(bus_load),
    .o_take(bus_take)
  );

  ngr_strap_latch u_strap (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_strap(i_strap_repeater),
    .i_an_enable(i_an_enable),
    .o_value(strap_value),
    .o_load(strap_load)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic rx_more_r;
  logic rx_ack_r;
  logic rx_fmt_r;
  logic rx_comply_r;
  logic rx_alt_r;
  logic [RXP_CODE_HI:RXP_CODE_LO] rx_code_r;
  logic page_rx_r;
  logic [GC_TEST_HI-GC_TEST_LO:0] gc_test_r;
  logic gc_ms_en_r;
  logic gc_ms_val_r;
  logic gc_rep_r;
  logic [REG_W-1:0] rx_page_word;
  logic [REG_W-1:0] gc_word;
  logic [REG_W-1:0] st_word;
  logic page_evt;
  logic status_read;
  logic gc_write;

  assign page_evt = i_clk_en & i_page_valid;
  assign status_read = bus_take & i_avs_read & (i_avs_address == ADDR_NEG_STATUS);
  assign gc_write = bus_take & i_avs_write & (i_avs_address == ADDR_GIG_CTRL)
                    & i_avs_byteenable[GC_BYTE_LANE];

  always_comb begin
    rx_page_word = RXP_RESET;
    rx_page_word[RXP_MORE_BIT] = rx_more_r;
    rx_page_word[RXP_ACK_BIT] = rx_ack_r;
    rx_page_word[RXP_FMT_BIT] = rx_fmt_r;
    rx_page_word[RXP_COMPLY_BIT] = rx_comply_r;
    rx_page_word[RXP_ALT_BIT] = rx_alt_r;
    rx_page_word[RXP_CODE_HI:RXP_CODE_LO] = rx_code_r;
  end

  // reserved and out-of-scope low bits read as zero
  always_comb begin
    gc_word = '0;
    gc_word[GC_TEST_HI:GC_TEST_LO] = gc_test_r;
    gc_word[GC_MS_EN_BIT] = gc_ms_en_r;
    gc_word[GC_MS_VAL_BIT] = gc_ms_val_r;
    gc_word[GC_REP_BIT] = gc_rep_r;
  end

  always_comb begin
    st_word = '0;
    st_word[ST_PAGE_RX_BIT] = page_rx_r;
  end

  // ----------------------------------------------------------------
  // received page capture
  // ----------------------------------------------------------------
  // only the negotiation side loads this register; no bus path exists
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_more_r <= RXP_RESET[RXP_MORE_BIT];
      rx_ack_r <= RXP_RESET[RXP_ACK_BIT];
      rx_fmt_r <= RXP_RESET[RXP_FMT_BIT];
      rx_comply_r <= RXP_RESET[RXP_COMPLY_BIT];
      rx_alt_r <= RXP_RESET[RXP_ALT_BIT];
      rx_code_r <= RXP_RESET[RXP_CODE_HI:RXP_CODE_LO];
    end else if (page_evt) begin
      rx_more_r <= i_page_word[RXP_MORE_BIT];
      rx_ack_r <= i_page_word[RXP_ACK_BIT];
      rx_fmt_r <= i_page_word[RXP_FMT_BIT];
      rx_comply_r <= i_page_word[RXP_COMPLY_BIT];
      rx_alt_r <= i_page_word[RXP_ALT_BIT];
      rx_code_r <= i_page_word[RXP_CODE_HI:RXP_CODE_LO];
    end
  end

  // a repeated alternating bit means the exchange lost step
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_alt_bit_error <= 1'b0;
    end else if (page_evt) begin
      o_alt_bit_error <= (i_page_word[RXP_ALT_BIT] == rx_alt_r);
    end
  end

  // ----------------------------------------------------------------
  // page received flag, latched high, cleared by reading status
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      page_rx_r <= 1'b0;
    end else if (page_evt) begin
      page_rx_r <= 1'b1;
    end else if (status_read) begin
      page_rx_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // gigabit control
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gc_test_r <= GC_TEST_RESET;
      gc_ms_en_r <= GC_BIT_RESET;
      gc_ms_val_r <= GC_BIT_RESET;
    end else if (gc_write) begin
      gc_test_r <= i_avs_writedata[GC_TEST_HI:GC_TEST_LO];
      gc_ms_en_r <= i_avs_writedata[GC_MS_EN_BIT];
      gc_ms_val_r <= i_avs_writedata[GC_MS_VAL_BIT];
    end
  end

  // strap load wins over a bus write taken on the same edge
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gc_rep_r <= GC_BIT_RESET;
    end else if (i_clk_en && strap_load) begin
      gc_rep_r <= strap_value;
    end else if (gc_write) begin
      gc_rep_r <= i_avs_writedata[GC_REP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // registered controls toward the transmitter and negotiation
  // ----------------------------------------------------------------
  // undefined test codes fall back to normal so the line never misbehaves
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_test_mode <= TM_NORMAL;
    end else if (i_clk_en) begin
      case (gc_test_r)
        TM_MODE1: o_test_mode <= TM_MODE1;
        TM_MODE2: o_test_mode <= TM_MODE2;
        TM_MODE3: o_test_mode <= TM_MODE3;
        TM_MODE4: o_test_mode <= TM_MODE4;
        default: o_test_mode <= TM_NORMAL;
      endcase
    end
  end

  // forcing a role can block a gigabit link if the partner disagrees
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ms_manual_en <= 1'b0;
      o_ms_force_master <= 1'b0;
      o_adv_repeater <= 1'b0;
      o_page_received <= 1'b0;
    end else if (i_clk_en) begin
      o_ms_manual_en <= gc_ms_en_r;
      o_ms_force_master <= gc_ms_en_r & gc_ms_val_r;
      o_adv_repeater <= gc_rep_r;
      o_page_received <= page_rx_r;
    end
  end

  // ----------------------------------------------------------------
  // read data, captured as the wait state ends
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= '0;
    end else if (bus_load) begin
      case (i_avs_address)
        ADDR_RX_PAGE: o_avs_readdata <= {16'h0000, rx_page_word};
        ADDR_GIG_CTRL: o_avs_readdata <= {16'h0000, gc_word};
        ADDR_NEG_STATUS: o_avs_readdata <= {16'h0000, st_word};
        default: o_avs_readdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_rx_page_capture: assert property (
    page_evt |=> rx_page_word == $past(i_page_word))
    else $error("received page does not match captured word");

  a_rx_code_hold: assert property (
    !page_evt |=> rx_code_r == $past(rx_code_r) && rx_fmt_r == $past(rx_fmt_r))
    else $error("code or page format changed without a page");

  a_rx_write_ignored: assert property (
    bus_take && i_avs_write && i_avs_address == ADDR_RX_PAGE && !page_evt
    |=> $stable(rx_page_word))
    else $error("write altered received page");

  a_page_flag_set: assert property (
    page_evt |=> page_rx_r ##1 (o_page_received || !$past(i_clk_en)))
    else $error("page flag not set by arriving page");

  a_page_flag_clear: assert property (
    status_read && !page_evt |=> !page_rx_r)
    else $error("page flag not cleared by status read");

  a_status_read_value: assert property (
    bus_load && i_avs_read && i_avs_address == ADDR_NEG_STATUS
    |=> o_avs_readdata[ST_PAGE_RX_BIT] == $past(page_rx_r) && !o_avs_waitrequest)
    else $error("status read returned wrong flag");

  a_test_mode_map: assert property (
    i_clk_en && gc_test_r > TM_MODE4 |=> o_test_mode == TM_NORMAL)
    else $error("undefined test code not mapped to normal");

  a_ms_force: assert property (
    i_clk_en && !gc_ms_en_r |=> !o_ms_force_master)
    else $error("role forced while manual mode disabled");

  a_ms_write: assert property (
    gc_write |=> gc_ms_en_r == $past(i_avs_writedata[GC_MS_EN_BIT]) ##1
    (o_ms_manual_en == $past(gc_ms_en_r) || !$past(i_clk_en)))
    else $error("manual enable write not reflected");

  a_alt_check: assert property (
    page_evt && i_page_word[RXP_ALT_BIT] != rx_alt_r |=> !o_alt_bit_error)
    else $error("alternating bit flagged though it flipped");

  a_strap_default: assert property (
    i_clk_en && strap_load |=> gc_rep_r == $past(strap_value))
    else $error("device type not loaded from strap");

  a_alt_repeat: assert property (
    page_evt && i_page_word[RXP_ALT_BIT] == rx_alt_r |=> o_alt_bit_error)
    else $error("repeated alternating bit not flagged");

  a_test_mode_pass: assert property (
    i_clk_en && gc_test_r <= TM_MODE4 |=> o_test_mode == $past(gc_test_r))
    else $error("defined test code not passed to transmitter");

  a_ms_value_write: assert property (
    gc_write |=> gc_ms_val_r == $past(i_avs_writedata[GC_MS_VAL_BIT]))
    else $error("manual role value write not reflected");

  a_rep_write: assert property (
    gc_write && !strap_load |=> gc_rep_r == $past(i_avs_writedata[GC_REP_BIT]))
    else $error("device type write not reflected");

endmodule : ngr_regs

`default_nettype wire

// ===== pkg/ngr_pkg.sv
// constants shared by the received-page and gigabit-control register block
`default_nettype none

package ngr_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;

  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_NEG_STATUS = 6'h06;
  localparam logic [5:0] IDX_RX_PAGE = 6'h08;
  localparam logic [5:0] IDX_GIG_CTRL = 6'h09;
  localparam logic [ADDR_W-1:0] ADDR_NEG_STATUS = {IDX_NEG_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RX_PAGE = {IDX_RX_PAGE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_GIG_CTRL = {IDX_GIG_CTRL, 2'b00};

  // ----------------------------------------------------------------
  // received_next_page fields
  // ----------------------------------------------------------------
  localparam int unsigned RXP_MORE_BIT = 15;
  localparam int unsigned RXP_ACK_BIT = 14;
  localparam int unsigned RXP_FMT_BIT = 13;
  localparam int unsigned RXP_COMPLY_BIT = 12;
  localparam int unsigned RXP_ALT_BIT = 11;
  localparam int unsigned RXP_CODE_HI = 10;
  localparam int unsigned RXP_CODE_LO = 0;
  localparam logic [REG_W-1:0] RXP_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // gigabit_control fields
  // ----------------------------------------------------------------
  localparam int unsigned GC_TEST_HI = 15;
  localparam int unsigned GC_TEST_LO = 13;
  localparam int unsigned GC_MS_EN_BIT = 12;
  localparam int unsigned GC_MS_VAL_BIT = 11;
  localparam int unsigned GC_REP_BIT = 10;
  localparam int unsigned GC_BYTE_LANE = 1;
  localparam logic [2:0] GC_TEST_RESET = 3'h0;
  localparam logic GC_BIT_RESET = 1'b0;

  localparam logic [2:0] TM_NORMAL = 3'h0;
  localparam logic [2:0] TM_MODE1 = 3'h1;
  localparam logic [2:0] TM_MODE2 = 3'h2;
  localparam logic [2:0] TM_MODE3 = 3'h3;
  localparam logic [2:0] TM_MODE4 = 3'h4;

  // ----------------------------------------------------------------
  // negotiation status fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_PAGE_RX_BIT = 1;

  typedef enum logic {
    NGR_BUS_IDLE,
    NGR_BUS_ACK
  } ngr_bus_state_e;

endpackage : ngr_pkg

`default_nettype wire

// ===== rtl/ngr_bus_slave.sv
// avalon-mm handshake: one wait state, then the request is taken
`default_nettype none

module ngr_bus_slave
  import ngr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_read,
  input wire logic i_write,
  output logic o_waitrequest,
  output logic o_load,
  output logic o_take
);

  ngr_bus_state_e state_r;
  logic req;

  assign req = i_read | i_write;
  // read data are captured on entry so they stand when wait drops
  assign o_load = i_clk_en & req & (state_r == NGR_BUS_IDLE);
  assign o_take = i_clk_en & req & (state_r == NGR_BUS_ACK);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= NGR_BUS_IDLE;
      o_waitrequest <= 1'b1;
    end else if (i_clk_en) begin
      case (state_r)
        NGR_BUS_IDLE: begin
          if (req) begin
            state_r <= NGR_BUS_ACK;
            o_waitrequest <= 1'b0;
          end
        end
        NGR_BUS_ACK: begin
          state_r <= NGR_BUS_IDLE;
          o_waitrequest <= 1'b1;
        end
        default: begin
          state_r <= NGR_BUS_IDLE;
          o_waitrequest <= 1'b1;
        end
      endcase
    end
  end

endmodule : ngr_bus_slave

`default_nettype wire

// ===== rtl/ngr_strap_latch.sv
// catches the device-type strap once, at the first enabled edge after reset
`default_nettype none

module ngr_strap_latch (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_strap,
  input wire logic i_an_enable,
  output logic o_value,
  output logic o_load
);

  logic done_r;

  // strap is sampled by a clocked edge, never by the async reset itself
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_r <= 1'b0;
      o_load <= 1'b0;
      o_value <= 1'b0;
    end else if (i_clk_en) begin
      o_load <= ~done_r;
      done_r <= 1'b1;
      if (!done_r) begin
        o_value <= i_strap & i_an_enable;
      end
    end
  end

endmodule : ngr_strap_latch

`default_nettype wire

// ===== verification/ngr_link_partner.sv
// link partner model: hands received next pages to the block one at a time
`default_nettype none

module ngr_link_partner
  import ngr_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_send,
  input wire logic [REG_W-1:0] i_word,
  output logic o_page_valid,
  output logic [REG_W-1:0] o_page_word
);
  timeunit 1ns;
  timeprecision 1ps;

  // word only means something with valid; between pages it churns so nothing leans on it
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_page_valid <= 1'b0;
      o_page_word <= 16'h0000;
    end else begin
      o_page_valid <= i_send;
      o_page_word <= i_send ? i_word : ~o_page_word;
    end
  end
endmodule : ngr_link_partner

`default_nettype wire

// ===== verification/test_ngr_regs.sv
// self-checking bench for the received-page and gigabit-control registers
`default_nettype none

module test_ngr_regs
  import ngr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic an_en = 1'b1;
  logic strap = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic send = 1'b0;
  logic [15:0] word = 16'h0000;
  logic page_valid;
  logic [15:0] page_word;
  logic [2:0] test_mode;
  logic ms_en;
  logic ms_master;
  logic adv_rep;
  logic page_rx;
  logic alt_err;
  logic [31:0] rd;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] pages [5] = '{16'h8000, 16'h4000, 16'h2555, 16'h1000, 16'h0FFF};

  always #5 core_clk = ~core_clk;

  ngr_link_partner i_ngr_link_partner (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_send(send), .i_word(word),
    .o_page_valid(page_valid), .o_page_word(page_word)
  );

  ngr_regs i_ngr_regs (
    .i_core_clk(core_clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .i_page_valid(page_valid), .i_page_word(page_word),
    .i_strap_repeater(strap), .i_an_enable(an_en),
    .o_test_mode(test_mode), .o_ms_manual_en(ms_en), .o_ms_force_master(ms_master),
    .o_adv_repeater(adv_rep), .o_page_received(page_rx), .o_alt_bit_error(alt_err)
  );

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_reg

  task automatic chk_pin(input string name, input logic [2:0] exp, input logic [2:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_pin

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // whole run needs under two hundred cycles; generous ceiling for a hung handshake
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // bus and page drivers
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] b);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= b;
    avs_write <= 1'b1;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    avs_write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd

  // partner adds one cycle, capture one more, flag output a third
  task automatic send_page(input logic [15:0] w);
    @(posedge core_clk);
    send <= 1'b1;
    word <= w;
    @(posedge core_clk);
    send <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : send_page

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    // strap needs two edges to land in the control register
    repeat (3) @(posedge core_clk);
    bus_rd(ADDR_RX_PAGE, rd);
    chk_reg("rx page reset", 32'h0000_0000, rd);
    bus_rd(ADDR_GIG_CTRL, rd);
    chk_reg("gig ctrl reset", 32'h0000_0400, rd);
    chk_pin("adv repeater", 3'h1, {2'b00, adv_rep});
    for (int i = 0; i < 5; i++) begin
      send_page(pages[i]);
      bus_rd(ADDR_RX_PAGE, rd);
      chk_reg("rx page", {16'h0000, pages[i]}, rd);
    end
    chk_pin("alt error", 3'h0, {2'b00, alt_err});
    send_page(16'h0800);
    chk_pin("alt error", 3'h1, {2'b00, alt_err});
    chk_pin("page flag", 3'h1, {2'b00, page_rx});
    bus_wr(ADDR_RX_PAGE, 16'hFFFF, 4'hF);
    bus_rd(ADDR_RX_PAGE, rd);
    chk_reg("rx page after write", 32'h0000_0800, rd);
    bus_rd(ADDR_NEG_STATUS, rd);
    chk_reg("status first", 32'h0000_0002, rd);
    bus_rd(ADDR_NEG_STATUS, rd);
    chk_reg("status second", 32'h0000_0000, rd);
    repeat (2) @(posedge core_clk);
    chk_pin("page flag", 3'h0, {2'b00, page_rx});
    // a page offered while the core is frozen must leave no trace
    clk_en <= 1'b0;
    send_page(16'h8123);
    clk_en <= 1'b1;
    bus_rd(ADDR_RX_PAGE, rd);
    chk_reg("rx page frozen", 32'h0000_0800, rd);
    chk_pin("alt error frozen", 3'h1, {2'b00, alt_err});
    chk_pin("page flag frozen", 3'h0, {2'b00, page_rx});
    for (int m = 0; m < 8; m++) begin
      bus_wr(ADDR_GIG_CTRL, {m[2:0], 13'h0000}, 4'h3);
      bus_rd(ADDR_GIG_CTRL, rd);
      chk_reg("test mode reg", {16'h0000, m[2:0], 13'h0000}, rd);
      chk_pin("test mode out", (m < 5) ? m[2:0] : TM_NORMAL, test_mode);
    end
    chk_pin("adv repeater", 3'h0, {2'b00, adv_rep});
    // forcing master can block a gigabit link against a forced partner
    bus_wr(ADDR_GIG_CTRL, 16'h1800, 4'h3);
    bus_rd(ADDR_GIG_CTRL, rd);
    chk_reg("manual master", 32'h0000_1800, rd);
    chk_pin("manual enable", 3'h1, {2'b00, ms_en});
    chk_pin("force master", 3'h1, {2'b00, ms_master});
    bus_wr(ADDR_GIG_CTRL, 16'h0C00, 4'h3);
    bus_rd(ADDR_GIG_CTRL, rd);
    chk_reg("auto role", 32'h0000_0C00, rd);
    chk_pin("manual enable", 3'h0, {2'b00, ms_en});
    chk_pin("force master", 3'h0, {2'b00, ms_master});
    chk_pin("adv repeater", 3'h1, {2'b00, adv_rep});
    bus_wr(ADDR_GIG_CTRL, 16'hE000, 4'hD);
    bus_wr(8'h3C, 16'hFFFF, 4'hF);
    bus_rd(8'h3C, rd);
    chk_reg("unmapped", 32'h0000_0000, rd);
    bus_rd(ADDR_GIG_CTRL, rd);
    chk_reg("gig ctrl kept", 32'h0000_0C00, rd);
    // second reset with negotiation off: device type defaults to zero
    rst_n <= 1'b0;
    an_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus_rd(ADDR_GIG_CTRL, rd);
    chk_reg("gig ctrl reset no neg", 32'h0000_0000, rd);
    chk_pin("adv repeater no neg", 3'h0, {2'b00, adv_rep});
    bus_rd(ADDR_RX_PAGE, rd);
    chk_reg("rx page reset again", 32'h0000_0000, rd);
    give_verdict();
  end
endmodule : test_ngr_regs

`default_nettype wire
